// file: core/ppm_pkg.sv
// Purpose: shared constants for the port monitor / configuration register bank
// Assumes: 10 MHz system clock, current results scaled at the nominal sense resistor
// Notes: thresholds are held as current-result counts so the compare needs no arithmetic
package ppm_pkg;
   // -----------------------------------------------------------------
   // command codes (register locations)
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_DEFER_TIMER = 8'h27;
   localparam logic [7:0] CMD_DISC_THRESH = 8'h29;
   localparam logic [7:0] CMD_OC_LIMIT_12 = 8'h2A;
   localparam logic [7:0] CMD_OC_LIMIT_34 = 8'h2B;
   localparam logic [7:0] CMD_DIE_TEMP = 8'h2C;
   localparam logic [7:0] CMD_VIN_LOW = 8'h2E;
   localparam logic [7:0] CMD_VIN_HIGH = 8'h2F;
   localparam logic [7:0] CMD_P1_CUR_LOW = 8'h30;
   localparam logic [7:0] CMD_P1_CUR_HIGH = 8'h31;
   localparam logic [7:0] CMD_P2_CUR_LOW = 8'h34;
   localparam logic [7:0] CMD_P2_CUR_HIGH = 8'h35;
   localparam logic [7:0] CMD_P3_CUR_LOW = 8'h38;
   localparam logic [7:0] CMD_P3_CUR_HIGH = 8'h39;

   // -----------------------------------------------------------------
   // widths, field layout, reset values
   // -----------------------------------------------------------------
   localparam int NUM_PORTS = 4;
   localparam int MEAS_W = 14;
   localparam int DEFER_W = 4;
   localparam int DISC_SEL_W = 2;
   localparam int OC_SEL_W = 3;
   localparam int OC_HI_LSB = 4;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [13:0] MEAS_RESET = 14'h0000;
   localparam logic [3:0] DEFER_OFF = 4'h0;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int DEFER_STEP_MS = 10;
   localparam int DEFER_STEP_CYC = (CLK_HZ / 1000) * DEFER_STEP_MS;

   // -----------------------------------------------------------------
   // disconnect thresholds in counts of 61.039 uA: 7.5, 15, 30, 50 mA
   // -----------------------------------------------------------------
   localparam logic [13:0] DISC_TH_0 = 14'h007B;
   localparam logic [13:0] DISC_TH_1 = 14'h00F6;
   localparam logic [13:0] DISC_TH_2 = 14'h01EB;
   localparam logic [13:0] DISC_TH_3 = 14'h0333;

   // -----------------------------------------------------------------
   // cut limits in counts: 374, 110, 204, 374, 754, 592, 645, 920 mA
   // -----------------------------------------------------------------
   localparam logic [13:0] OC_TH_0 = 14'h17EF;
   localparam logic [13:0] OC_TH_1 = 14'h070A;
   localparam logic [13:0] OC_TH_2 = 14'h0D0E;
   localparam logic [13:0] OC_TH_3 = 14'h17EF;
   localparam logic [13:0] OC_TH_4 = 14'h3041;
   localparam logic [13:0] OC_TH_5 = 14'h25E3;
   localparam logic [13:0] OC_TH_6 = 14'h2947;
   localparam logic [13:0] OC_TH_7 = 14'h3AE0;
endpackage : ppm_pkg

// file: core/ppm_regs.sv
// Purpose: deferral timer, per-port disconnect and overcurrent supervision, measurement readback
// Assumes: the serial front end delivers decoded bytes as one-cycle strobes
// Notes: the command byte sets a pointer that auto-increments on every data byte
`timescale 1ns/100ps
module ppm_regs #(
   parameter int EVT_W = 8,                                // non-critical / critical event lines
   parameter int DEFER_STEP_CYCLES = ppm_pkg::DEFER_STEP_CYC, // one deferral step in clocks
   parameter int DISC_TIMEOUT_CYCLES = 3000000,            // disconnect timeout in clocks
   parameter int OC_FAULT_CYCLES = 600000                  // overcurrent fault time in clocks
) (
   input wire logic I_CLK_SYS,                      // system clock, 10 MHz
   input wire logic I_RESET,                        // synchronous reset, active high
   input wire logic I_CMD_STB,                      // byte on I_BYTE is a command code
   input wire logic I_WR_STB,                       // byte on I_BYTE is write data
   input wire logic [7:0] I_BYTE,                   // decoded serial byte
   input wire logic I_RD_STB,                       // host requests the next read byte
   output logic [7:0] O_RD_DATA,                    // read byte, valid from the edge after I_RD_STB
   input wire logic [EVT_W-1:0] I_NONCRIT_EVT,      // non-critical event pulses
   input wire logic [EVT_W-1:0] I_CRIT_EVT,         // critical event pulses
   output logic [EVT_W-1:0] O_NONCRIT_FWD,          // non-critical events to interrupt logic
   output logic [EVT_W-1:0] O_CRIT_FWD,             // critical events to interrupt logic
   input wire logic [3:0] I_PORT_POWERED,           // port n is powered
   input wire logic [4*14-1:0] I_PORT_CURRENT,      // live current results, port 1 in low bits
   input wire logic I_CUR_VALID,                    // I_PORT_CURRENT holds a fresh result
   input wire logic [7:0] I_TEMP,                   // temperature conversion result
   input wire logic I_TEMP_VALID,                   // I_TEMP fresh
   input wire logic [13:0] I_VIN,                   // input voltage conversion result
   input wire logic I_VIN_VALID,                    // I_VIN fresh
   output logic [3:0] O_PORT_DISCONNECT,            // pulse: disconnect timeout expired
   output logic [3:0] O_PORT_OC_FAULT               // pulse: overcurrent fault, shut port
);
   localparam int NP = ppm_pkg::NUM_PORTS;
   localparam int MW = ppm_pkg::MEAS_W;

   // -----------------------------------------------------------------
   // host-visible configuration and measurement storage
   // -----------------------------------------------------------------
   logic [7:0] cmd_ptr;
   logic [7:0] interrupt_defer_timer;
   logic [7:0] disconnect_threshold_cfg;
   logic [7:0] overcurrent_limit_ports_1_2;
   logic [7:0] overcurrent_limit_ports_3_4;
   logic [7:0] die_temperature;
   logic [MW-1:0] supply_voltage;
   logic [MW-1:0] port_current [NP];
   logic [5:0] high_shadow;
   logic [7:0] next_rd_data;

   // command byte loads the pointer, each data byte moves it on
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         cmd_ptr <= ppm_pkg::REG_RESET;
      end else if (I_CMD_STB) begin
         cmd_ptr <= I_BYTE;
      end else if (I_WR_STB || I_RD_STB) begin
         cmd_ptr <= cmd_ptr + 8'h01;
      end
   end

   // writable registers; writes to read-only codes are dropped
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         interrupt_defer_timer <= ppm_pkg::REG_RESET;
         disconnect_threshold_cfg <= ppm_pkg::REG_RESET;
         overcurrent_limit_ports_1_2 <= ppm_pkg::REG_RESET;
         overcurrent_limit_ports_3_4 <= ppm_pkg::REG_RESET;
      end else if (I_WR_STB) begin
         unique case (cmd_ptr)
            ppm_pkg::CMD_DEFER_TIMER: interrupt_defer_timer <= I_BYTE;
            ppm_pkg::CMD_DISC_THRESH: disconnect_threshold_cfg <= I_BYTE;
            ppm_pkg::CMD_OC_LIMIT_12: overcurrent_limit_ports_1_2 <= I_BYTE;
            ppm_pkg::CMD_OC_LIMIT_34: overcurrent_limit_ports_3_4 <= I_BYTE;
            default: ;
         endcase
      end
   end

   // measurement capture; all results clear on reset
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         die_temperature <= ppm_pkg::REG_RESET;
         supply_voltage <= ppm_pkg::MEAS_RESET;
      end else begin
         if (I_TEMP_VALID) begin
            die_temperature <= I_TEMP;
         end
         if (I_VIN_VALID) begin
            supply_voltage <= I_VIN;
         end
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   // high byte comes from a shadow taken at the low-byte read, so a result
   // that updates between the two bytes cannot tear the 14-bit value
   always_comb begin
      next_rd_data = ppm_pkg::READ_UNMAPPED;
      unique case (cmd_ptr)
         ppm_pkg::CMD_DEFER_TIMER: next_rd_data = interrupt_defer_timer;
         ppm_pkg::CMD_DISC_THRESH: next_rd_data = disconnect_threshold_cfg;
         ppm_pkg::CMD_OC_LIMIT_12: next_rd_data = overcurrent_limit_ports_1_2;
         ppm_pkg::CMD_OC_LIMIT_34: next_rd_data = overcurrent_limit_ports_3_4;
         ppm_pkg::CMD_DIE_TEMP: next_rd_data = die_temperature;
         ppm_pkg::CMD_VIN_LOW: next_rd_data = supply_voltage[7:0];
         ppm_pkg::CMD_P1_CUR_LOW: next_rd_data = port_current[0][7:0];
         ppm_pkg::CMD_P2_CUR_LOW: next_rd_data = port_current[1][7:0];
         ppm_pkg::CMD_P3_CUR_LOW: next_rd_data = port_current[2][7:0];
         ppm_pkg::CMD_VIN_HIGH, ppm_pkg::CMD_P1_CUR_HIGH,
         ppm_pkg::CMD_P2_CUR_HIGH, ppm_pkg::CMD_P3_CUR_HIGH: next_rd_data = {2'b00, high_shadow};
         default: next_rd_data = ppm_pkg::READ_UNMAPPED;
      endcase
   end

   // read data register and high-byte shadow
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_RD_DATA <= ppm_pkg::REG_RESET;
         high_shadow <= 6'h00;
      end else if (I_RD_STB) begin
         O_RD_DATA <= next_rd_data;
         unique case (cmd_ptr)
            ppm_pkg::CMD_VIN_LOW: high_shadow <= supply_voltage[13:8];
            ppm_pkg::CMD_P1_CUR_LOW: high_shadow <= port_current[0][13:8];
            ppm_pkg::CMD_P2_CUR_LOW: high_shadow <= port_current[1][13:8];
            ppm_pkg::CMD_P3_CUR_LOW: high_shadow <= port_current[2][13:8];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // interrupt deferral
   // -----------------------------------------------------------------
   logic [3:0] defer_n;
   logic [31:0] step_cnt;
   logic [3:0] interval_cnt;
   logic step_tick;
   logic release_now;
   logic [EVT_W-1:0] pending;

   // upper four bits are stored but steer nothing; host leaves them at zero
   assign defer_n = interrupt_defer_timer[ppm_pkg::DEFER_W-1:0];
   assign step_tick = (step_cnt == 32'(DEFER_STEP_CYCLES - 1));
   assign release_now = step_tick && (interval_cnt <= 4'h1);

   // 10 ms step prescaler, free running so the period stays N steps
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET || defer_n == ppm_pkg::DEFER_OFF || step_tick) begin
         step_cnt <= 32'h00000000;
      end else begin
         step_cnt <= step_cnt + 32'h00000001;
      end
   end

   // interval counter counts N steps down, then reloads from the field
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         interval_cnt <= ppm_pkg::DEFER_OFF;
      end else if (I_WR_STB && cmd_ptr == ppm_pkg::CMD_DEFER_TIMER) begin
         interval_cnt <= I_BYTE[ppm_pkg::DEFER_W-1:0];
      end else if (step_tick) begin
         interval_cnt <= release_now ? defer_n : interval_cnt - 4'h1;
      end
   end

   // pending events; a new event in the release cycle is kept for the next window
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET || defer_n == ppm_pkg::DEFER_OFF) begin
         pending <= '0;
      end else if (release_now) begin
         pending <= I_NONCRIT_EVT;
      end else begin
         pending <= pending | I_NONCRIT_EVT;
      end
   end

   // forwarding stage
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_NONCRIT_FWD <= '0;
         O_CRIT_FWD <= '0;
      end else begin
         O_CRIT_FWD <= I_CRIT_EVT;
         if (defer_n == ppm_pkg::DEFER_OFF) begin
            O_NONCRIT_FWD <= I_NONCRIT_EVT;
         end else if (release_now) begin
            O_NONCRIT_FWD <= pending;
         end else begin
            O_NONCRIT_FWD <= '0;
         end
      end
   end

   // -----------------------------------------------------------------
   // per-port supervision
   // -----------------------------------------------------------------
   // counts are 61.039 uA each at the nominal sense resistor; a different
   // resistor shifts every threshold by the same ratio
   function automatic logic [13:0] disc_thresh(input logic [1:0] sel);
      unique case (sel)
         2'b00: disc_thresh = ppm_pkg::DISC_TH_0;
         2'b01: disc_thresh = ppm_pkg::DISC_TH_1;
         2'b10: disc_thresh = ppm_pkg::DISC_TH_2;
         2'b11: disc_thresh = ppm_pkg::DISC_TH_3;
      endcase
   endfunction : disc_thresh

   function automatic logic [13:0] cut_thresh(input logic [2:0] sel);
      unique case (sel)
         3'b000: cut_thresh = ppm_pkg::OC_TH_0;
         3'b001: cut_thresh = ppm_pkg::OC_TH_1;
         3'b010: cut_thresh = ppm_pkg::OC_TH_2;
         3'b011: cut_thresh = ppm_pkg::OC_TH_3;
         3'b100: cut_thresh = ppm_pkg::OC_TH_4;
         3'b101: cut_thresh = ppm_pkg::OC_TH_5;
         3'b110: cut_thresh = ppm_pkg::OC_TH_6;
         3'b111: cut_thresh = ppm_pkg::OC_TH_7;
      endcase
   endfunction : cut_thresh

   logic [15:0] oc_cfg;
   assign oc_cfg = {overcurrent_limit_ports_3_4, overcurrent_limit_ports_1_2};

   genvar p;
   generate
      for (p = 0; p < NP; p++) begin : g_port
         logic [MW-1:0] live_cur;
         logic [1:0] disc_sel;
         logic [2:0] oc_sel;
         logic [31:0] disc_cnt;
         logic [31:0] oc_cnt;
         logic below;
         logic above;

         assign live_cur = I_PORT_CURRENT[p*MW +: MW];
         assign disc_sel = disconnect_threshold_cfg[p*ppm_pkg::DISC_SEL_W +: ppm_pkg::DISC_SEL_W];
         assign oc_sel = oc_cfg[p*ppm_pkg::OC_HI_LSB +: ppm_pkg::OC_SEL_W];
         assign below = I_PORT_POWERED[p] && (live_cur < disc_thresh(disc_sel));
         assign above = I_PORT_POWERED[p] && (live_cur > cut_thresh(oc_sel));

         // latest current result for this port
         always_ff @(posedge I_CLK_SYS) begin
            if (I_RESET) begin
               port_current[p] <= ppm_pkg::MEAS_RESET;
            end else if (I_CUR_VALID) begin
               port_current[p] <= live_cur;
            end
         end

         // disconnect timeout restarts whenever current recovers
         always_ff @(posedge I_CLK_SYS) begin
            if (I_RESET || !below) begin
               disc_cnt <= 32'h00000000;
               O_PORT_DISCONNECT[p] <= 1'b0;
            end else begin
               disc_cnt <= (disc_cnt == 32'(DISC_TIMEOUT_CYCLES - 1)) ? 32'h00000000 : disc_cnt + 32'h00000001;
               O_PORT_DISCONNECT[p] <= (disc_cnt == 32'(DISC_TIMEOUT_CYCLES - 1));
            end
         end

         // fault timer counts down to terminal zero while over the cut limit
         always_ff @(posedge I_CLK_SYS) begin
            if (I_RESET || !above) begin
               oc_cnt <= 32'(OC_FAULT_CYCLES - 1);
               O_PORT_OC_FAULT[p] <= 1'b0;
            end else begin
               oc_cnt <= (oc_cnt == 32'h00000000) ? 32'(OC_FAULT_CYCLES - 1) : oc_cnt - 32'h00000001;
               O_PORT_OC_FAULT[p] <= (oc_cnt == 32'h00000000);
            end
         end
      end
   endgenerate
endmodule : ppm_regs

// file: tb/ppm_regs_monitor.sv
// Purpose: port-level checker for the register bank
// Assumes: the host leaves one quiet cycle between bytes
// Notes: bound to every ppm_regs instance
`timescale 1ns/100ps
module ppm_regs_monitor #(
   parameter int EVT_W = 8,                    // event lines
   parameter int DISC_TIMEOUT_CYCLES = 20,     // disconnect timeout
   parameter int OC_FAULT_CYCLES = 15          // overcurrent fault time
) (
   input wire logic I_CLK_SYS,                 // clock
   input wire logic I_RESET,                   // sync reset
   input wire logic I_CMD_STB,                 // command strobe
   input wire logic I_RD_STB,                  // read strobe
   input wire logic [7:0] I_BYTE,              // host byte
   input wire logic [7:0] O_RD_DATA,           // read byte
   input wire logic [EVT_W-1:0] I_NONCRIT_EVT, // deferrable events
   input wire logic [EVT_W-1:0] I_CRIT_EVT,    // critical events
   input wire logic [EVT_W-1:0] O_NONCRIT_FWD, // forwarded deferrable
   input wire logic [EVT_W-1:0] O_CRIT_FWD,    // forwarded critical
   input wire logic [3:0] I_PORT_POWERED,      // powered ports
   input wire logic [3:0] O_PORT_DISCONNECT,   // disconnect pulses
   input wire logic [3:0] O_PORT_OC_FAULT      // fault pulses
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);
   int pw_cnt [4];
   logic [3:0] dis_ok;
   logic [3:0] oc_ok;
   logic [EVT_W-1:0] seen;
   // powered run length per port; a pulse before the timeout has run is premature
   always_ff @(posedge I_CLK_SYS) begin
      for (int p = 0; p < 4; p++) begin
         pw_cnt[p] <= (I_RESET || !I_PORT_POWERED[p]) ? 0 : pw_cnt[p] + 1;
      end
   end
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         dis_ok[p] = !O_PORT_DISCONNECT[p] || pw_cnt[p] >= DISC_TIMEOUT_CYCLES;
         oc_ok[p] = !O_PORT_OC_FAULT[p] || pw_cnt[p] >= OC_FAULT_CYCLES;
      end
   end
   // events still owed; new ones are added after the clear so a back-to-back event is kept
   always_ff @(posedge I_CLK_SYS) begin
      seen <= I_RESET ? '0 : (seen & ~O_NONCRIT_FWD) | I_NONCRIT_EVT;
   end
   sequence s_point_gap;
      I_CMD_STB && I_BYTE == 8'h28;
   endsequence
   sequence s_read_req;
      I_RD_STB && !I_CMD_STB;
   endsequence
   a_crit_pass_through: assert property (!$past(I_RESET) |-> O_CRIT_FWD == $past(I_CRIT_EVT))
      else $error("critical event not forwarded after one cycle");
   a_fwd_has_cause: assert property ((O_NONCRIT_FWD & ~seen) == '0)
      else $error("deferrable event forwarded without a pending cause");
   a_read_holds: assert property (!I_RD_STB |=> $stable(O_RD_DATA))
      else $error("read byte changed without a read strobe");
   a_unmapped_zero: assert property (s_point_gap ##1 !I_RD_STB ##1 s_read_req |=> O_RD_DATA == 8'h00)
      else $error("unmapped location did not read zero");
   a_disc_time: assert property (O_PORT_DISCONNECT != 4'h0 |-> &dis_ok)
      else $error("disconnect before the timeout ran");
   a_fault_time: assert property (O_PORT_OC_FAULT != 4'h0 |-> &oc_ok)
      else $error("overcurrent fault before the fault time ran");
   a_disc_one_cycle: assert property (O_PORT_DISCONNECT != 4'h0 |=> (O_PORT_DISCONNECT & $past(O_PORT_DISCONNECT)) == 4'h0)
      else $error("disconnect pulse longer than one cycle");
   a_fault_one_cycle: assert property ((O_PORT_OC_FAULT & $past(O_PORT_OC_FAULT)) == 4'h0)
      else $error("fault pulse longer than one cycle");
endmodule : ppm_regs_monitor

bind ppm_regs ppm_regs_monitor #(.EVT_W(EVT_W), .DISC_TIMEOUT_CYCLES(DISC_TIMEOUT_CYCLES),
   .OC_FAULT_CYCLES(OC_FAULT_CYCLES)) u_ppm_regs_monitor (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
   .I_CMD_STB(I_CMD_STB), .I_RD_STB(I_RD_STB), .I_BYTE(I_BYTE), .O_RD_DATA(O_RD_DATA),
   .I_NONCRIT_EVT(I_NONCRIT_EVT), .I_CRIT_EVT(I_CRIT_EVT), .O_NONCRIT_FWD(O_NONCRIT_FWD),
   .O_CRIT_FWD(O_CRIT_FWD), .I_PORT_POWERED(I_PORT_POWERED), .O_PORT_DISCONNECT(O_PORT_DISCONNECT),
   .O_PORT_OC_FAULT(O_PORT_OC_FAULT));

// file: tb/ppm_host_model.sv
// Purpose: host controller stand-in sending decoded bytes
// Assumes: strobes change only at rising edges
// Notes: a quiet cycle follows each byte so no strobe re-rises at the edge that dropped it
`timescale 1ns/100ps
module ppm_host_model (
   input wire logic i_clk,           // system clock
   input wire logic [7:0] i_rd_data, // byte from the device
   output logic o_cmd_stb,           // command strobe
   output logic o_wr_stb,            // write strobe
   output logic o_rd_stb,            // read strobe
   output logic [7:0] o_byte         // byte to the device
);
   // quiet bus at time zero
   initial begin
      {o_cmd_stb, o_wr_stb, o_rd_stb} = 3'h0;
      o_byte = 8'h00;
   end
   // kind 0 command, 1 write, 2 read
   task automatic xfer(input int k, input logic [7:0] v);
      @(posedge i_clk);
      o_cmd_stb <= (k == 0);
      o_wr_stb <= (k == 1);
      o_rd_stb <= (k == 2);
      o_byte <= v;
      @(posedge i_clk);
      {o_cmd_stb, o_wr_stb, o_rd_stb} <= 3'h0;
      o_byte <= ~v; // no stale byte left on a released bus
   endtask : xfer
   // the byte is taken once the edge that saw the strobe has landed; pairs go low byte first
   task automatic send_rd(output logic [7:0] v);
      xfer(2, 8'h00);
      #1;
      v = i_rd_data;
   endtask : send_rd
endmodule : ppm_host_model

// file: tb/tb_ppm_regs.sv
// Purpose: self-checking bench for the register bank
// Assumes: short timing parameters stand in for the millisecond counts
// Notes: expectations come from the register map, never from the design
`timescale 1ns/100ps
module tb_ppm_regs;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd, wr, rd, cv = 1'b0, tv = 1'b0, vv = 1'b0;
   logic [7:0] byt, rdat, d, nev = 8'h00, cev = 8'h00, nfw, cfw, tmp = 8'h00;
   logic [3:0] pwr = 4'h0, dis, ocf;
   logic [55:0] cur = 56'h00000000000000;
   logic [13:0] vin = 14'h0000;
   int bad_count = 0;
   int total_checks = 0;
   int c, c2;
   // 100 ns clock
   initial begin
      forever #50 clk = ~clk;
   end
   ppm_regs #(.DEFER_STEP_CYCLES(10), .DISC_TIMEOUT_CYCLES(20), .OC_FAULT_CYCLES(15)) u_ppm_regs (
      .I_CLK_SYS(clk), .I_RESET(rst), .I_CMD_STB(cmd), .I_WR_STB(wr), .I_BYTE(byt), .I_RD_STB(rd),
      .O_RD_DATA(rdat), .I_NONCRIT_EVT(nev), .I_CRIT_EVT(cev), .O_NONCRIT_FWD(nfw), .O_CRIT_FWD(cfw),
      .I_PORT_POWERED(pwr), .I_PORT_CURRENT(cur), .I_CUR_VALID(cv), .I_TEMP(tmp), .I_TEMP_VALID(tv),
      .I_VIN(vin), .I_VIN_VALID(vv), .O_PORT_DISCONNECT(dis), .O_PORT_OC_FAULT(ocf));
   ppm_host_model u_ppm_host_model (.i_clk(clk), .i_rd_data(rdat), .o_cmd_stb(cmd), .o_wr_stb(wr),
      .o_rd_stb(rd), .o_byte(byt));
   task automatic chk(input string s, input logic [13:0] x, input logic [13:0] g);
      total_checks++;
      if (g !== x) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", s, x, g);
      end
   endtask : chk
   task automatic chkr(input string s, input int lo, input int hi, input int g);
      total_checks++;
      if (g < lo || g > hi) begin
         bad_count++;
         $display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, g);
      end
   endtask : chkr
   task automatic rd1(input logic [7:0] a, output logic [7:0] v);
      u_ppm_host_model.xfer(0, a);
      u_ppm_host_model.send_rd(v);
   endtask : rd1
   task automatic wr1(input logic [7:0] a, input logic [7:0] v);
      u_ppm_host_model.xfer(0, a);
      u_ppm_host_model.xfer(1, v);
   endtask : wr1
   // cycles until the chosen output shows; event pulses are dropped after one edge
   task automatic wait_ev(input int w, output int n);
      logic [3:0] hit;
      for (n = 0; n < 60; n++) begin
         @(posedge clk);
         nev <= 8'h00;
         cev <= 8'h00;
         #1;
         hit = {ocf[1], dis[0], cfw[0], nfw[0]};
         if (hit[w] === 1'b1) break;
      end
   endtask : wait_ev
   task automatic t_reset();
      logic [7:0] a [13] = '{8'h27, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h34, 8'h35, 8'h38, 8'h39};
      foreach (a[i]) begin
         rd1(a[i], d);
         chk("reset value", 14'h0000, 14'(d));
      end
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs();
      logic [7:0] cfg [3] = '{8'hE4, 8'h71, 8'h53};
      u_ppm_host_model.xfer(0, ppm_pkg::CMD_DISC_THRESH);
      foreach (cfg[i]) u_ppm_host_model.xfer(1, cfg[i]);
      u_ppm_host_model.xfer(0, ppm_pkg::CMD_DISC_THRESH);
      foreach (cfg[i]) begin
         u_ppm_host_model.send_rd(d);
         chk("selector fields", 14'(cfg[i]), 14'(d));
      end
      wr1(ppm_pkg::CMD_DIE_TEMP, 8'h5A);
      rd1(ppm_pkg::CMD_DIE_TEMP, d);
      chk("read-only temperature", 14'h0000, 14'(d));
      rd1(8'h28, d);
      chk("unmapped read", 14'h0000, 14'(d));
      $display("test registers done");
   endtask : t_regs
   task automatic t_meas();
      logic [7:0] a [4] = '{ppm_pkg::CMD_VIN_LOW, ppm_pkg::CMD_P1_CUR_LOW, ppm_pkg::CMD_P2_CUR_LOW, 8'h38};
      logic [13:0] want [4] = '{14'h2ABC, 14'h0155, 14'h2F0F, 14'h1234};
      logic [7:0] hi;
      @(posedge clk);
      {tv, vv, cv} <= 3'h7;
      tmp <= 8'hA5;
      vin <= want[0];
      cur <= {14'h0000, want[3], want[2], want[1]};
      @(posedge clk);
      {tv, vv, cv} <= 3'h0;
      rd1(ppm_pkg::CMD_DIE_TEMP, d);
      chk("temperature", 14'h00A5, 14'(d));
      foreach (a[i]) begin
         rd1(a[i], d);
         u_ppm_host_model.send_rd(hi);
         chk("result low byte", 14'(want[i][7:0]), 14'(d));
         chk("result high byte", 14'(want[i][13:8]), 14'(hi));
      end
      $display("test measurements done");
   endtask : t_meas
   task automatic t_defer();
      wr1(ppm_pkg::CMD_DEFER_TIMER, 8'h00);
      @(posedge clk);
      nev <= 8'h01;
      wait_ev(0, c);
      chkr("undeferred latency", 0, 1, c);
      wr1(ppm_pkg::CMD_DEFER_TIMER, 8'h02);
      @(posedge clk);
      cev <= 8'h01;
      wait_ev(1, c);
      chkr("critical latency", 0, 0, c);
      @(posedge clk);
      nev <= 8'h01;
      wait_ev(0, c);
      chkr("deferred release", 2, 21, c);
      @(posedge clk);
      nev <= 8'h01;
      wait_ev(0, c);
      chkr("deferral period", 18, 18, c);
      rd1(ppm_pkg::CMD_DEFER_TIMER, d);
      chk("deferral field", 14'h0002, 14'(d));
      $display("test deferral done");
   endtask : t_defer
   // port 1 sits just under its 123-count floor, port 2 just over its 15072-count cut
   task automatic t_super();
      @(posedge clk);
      cur <= {28'h0000000, 14'h3AE1, 14'h007A};
      pwr <= 4'h3;
      wait_ev(3, c);
      chkr("fault time", 14, 17, c);
      wait_ev(2, c2);
      chkr("disconnect time", 19, 22, c + c2 + 1);
      @(posedge clk);
      pwr <= 4'h0;
      $display("test supervision done");
   endtask : t_super
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   // main sequence after 20 cycles of reset
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_meas();
      t_defer();
      t_super();
      complete_run();
   end
   // the tests need under 2000 cycles; a hang is cut off well past that
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end
endmodule : tb_ppm_regs
